// [design/pic_pkg.sv]
package pic_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT0_IRQ_EN = 8'h04;
  localparam logic [7:0] IDX_PORT1_IRQ_EN = 8'h05;
  localparam logic [7:0] IDX_PORT0_IRQ_POL = 8'h06;
  localparam logic [7:0] IDX_PORT1_IRQ_POL = 8'h07;
  localparam logic [7:0] IDX_GLOBAL_IRQ_EN = 8'h20;
  localparam logic [7:0] IDX_EP_IRQ_EN = 8'h21;
  localparam logic [7:0] IDX_IRQ_PENDING = 8'h22;
  localparam logic [7:0] IDX_PROC_STATUS = 8'hFF;

  // processor status and control fields
  localparam int PSC_GIE_BIT = 2;
  localparam int PSC_PENDING_BIT = 7;

  // global interrupt enable register fields
  localparam int GE_BUS = 0;
  localparam int GE_T128 = 1;
  localparam int GE_T1024 = 2;
  localparam int GE_SPI = 3;
  localparam int GE_CAPA = 4;
  localparam int GE_CAPB = 5;
  localparam int GE_GPIO = 6;
  localparam int GE_WAKE = 7;

  // pending vector positions, index 0 is vector 1 (highest priority)
  localparam int NUM_SRC = 11;
  localparam int SRC_BUS = 0;
  localparam int SRC_T128 = 1;
  localparam int SRC_T1024 = 2;
  localparam int SRC_EP0 = 3;
  localparam int SRC_EP1 = 4;
  localparam int SRC_EP2 = 5;
  localparam int SRC_SPI = 6;
  localparam int SRC_CAPA = 7;
  localparam int SRC_CAPB = 8;
  localparam int SRC_GPIO = 9;
  localparam int SRC_WAKE = 10;

  // vector table
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0002;
  localparam logic [15:0] VECTOR_STEP = 16'h0002;

  // reset values
  localparam logic [7:0] GLOBAL_EN_RESET = 8'h00;
  localparam logic [2:0] EP_EN_RESET = 3'h0;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int CALL_CYCLES = 10;
  localparam int JUMP_CYCLES = 5;
  localparam int BUS_PERSIST_US = 256;
  localparam int BUS_PERSIST_CYC = BUS_PERSIST_US * CLK_MHZ;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CALL, SEQ_JUMP} pic_seq_e;
endpackage : pic_pkg

// [design/pic_gpio_edge.sv]
`timescale 1ns/1ps
module pic_gpio_edge #(
  parameter int PINS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [PINS-1:0] pins_i,
  input wire logic [PINS-1:0] pin_en_i,
  input wire logic [PINS-1:0] pol_i,
  input wire logic main_en_i,
  output logic fire_o
);
  logic [PINS-1:0] sync1_r, sync2_r, prev_r, lock_r;
  logic [PINS-1:0] lock_nxt, lvl, prev_lvl, qual;
  logic fire_r, fire_nxt;

  always_comb
  begin
    lvl = ~(sync2_r ^ pol_i);
    prev_lvl = ~(prev_r ^ pol_i);
    qual = lvl & ~prev_lvl & pin_en_i & {PINS{main_en_i}};
    lock_nxt = lock_r & pin_en_i & lvl;
    fire_nxt = 1'b0;
    if (lock_nxt == '0 && qual != '0)
    begin
      fire_nxt = 1'b1;
      lock_nxt = qual;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      lock_r <= '0;
      fire_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      lock_r <= lock_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign fire_o = fire_r;
endmodule : pic_gpio_edge

// [design/pic_ctrl.sv]
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int PINS = 16,
  parameter int PERSIST_CYC = BUS_PERSIST_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_cond_i,
  input wire logic tmr128_evt_i,
  input wire logic tmr1024_evt_i,
  input wire logic ep0_evt_i,
  input wire logic ep1_evt_i,
  input wire logic ep2_evt_i,
  input wire logic spi_byte_done_i,
  input wire logic capa_evt_i,
  input wire logic capb_evt_i,
  input wire logic wake_evt_i,
  input wire logic [PINS-1:0] gpio_pins_i,
  input wire logic instr_done_i,
  input wire logic irq_on_instruction_i,
  input wire logic irq_off_instruction_i,
  input wire logic return_from_handler_instruction_i,
  input wire logic [15:0] pc_i,
  input wire logic carry_flag_i,
  input wire logic zero_flag_i,
  input wire logic [15:0] pop_pc_i,
  input wire logic pop_carry_flag_i,
  input wire logic pop_zero_flag_i,
  output logic cpu_hold_o,
  output logic stack_push_o,
  output logic [15:0] push_pc_o,
  output logic push_carry_flag_o,
  output logic push_zero_flag_o,
  output logic vector_valid_o,
  output logic [15:0] fetch_addr_o,
  output logic restore_valid_o,
  output logic [15:0] restore_pc_o,
  output logic restore_carry_flag_o,
  output logic restore_zero_flag_o,
  output logic wake_timer_run_o
);
  function automatic logic [3:0] pick_first(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = 4'(i);
    end
    return idx;
  endfunction : pick_first

  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    return VECTOR_BASE + 16'(idx) * VECTOR_STEP;
  endfunction : vector_of

  // register file and bus slave
  logic [7:0] gen_r, gen_nxt;
  logic [2:0] epen_r, epen_nxt;
  logic [PINS-1:0] pin_en_r, pin_en_nxt, pol_r, pol_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] idx;
  logic wr, rd;
  // interrupt state
  logic [NUM_SRC-1:0] pend_r, pend_nxt, set_vec, en_vec, req_vec;
  logic gie_r, gie_nxt;
  logic gpio_fire;
  logic [15:0] bcnt_r, bcnt_nxt;
  logic bus_evt;
  // sequencer
  pic_seq_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt, vidx_r, vidx_nxt;
  logic take;
  logic push_r, push_nxt, vval_r, vval_nxt, rv_r, rv_nxt;
  logic [15:0] ppc_r, ppc_nxt, fetch_r, fetch_nxt, rpc_r, rpc_nxt;
  logic pc_r, pc_nxt, pz_r, pz_nxt, rc_r, rc_nxt, rz_r, rz_nxt;

  pic_gpio_edge #(.PINS(PINS)) u_gpio (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins_i(gpio_pins_i),
    .pin_en_i(pin_en_r),
    .pol_i(pol_r),
    .main_en_i(gen_r[GE_GPIO]),
    .fire_o(gpio_fire)
  );

  assign idx = wb_adr_i[9:2];
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
  assign rd = wb_cyc_i & wb_stb_i & ~ack_r;

  always_comb
  begin
    gen_nxt = gen_r;
    epen_nxt = epen_r;
    pin_en_nxt = pin_en_r;
    pol_nxt = pol_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = dat_r;
    if (wr)
    begin
      unique case (idx)
        IDX_GLOBAL_IRQ_EN: gen_nxt = wb_dat_i[7:0];
        IDX_EP_IRQ_EN: epen_nxt = wb_dat_i[2:0];
        IDX_PORT0_IRQ_EN: pin_en_nxt[7:0] = wb_dat_i[7:0];
        IDX_PORT1_IRQ_EN: pin_en_nxt[PINS-1:8] = wb_dat_i[PINS-9:0];
        IDX_PORT0_IRQ_POL: pol_nxt[7:0] = wb_dat_i[7:0];
        IDX_PORT1_IRQ_POL: pol_nxt[PINS-1:8] = wb_dat_i[PINS-9:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      dat_nxt = 32'h0000_0000;
      unique case (idx)
        IDX_GLOBAL_IRQ_EN: dat_nxt[7:0] = gen_r;
        IDX_EP_IRQ_EN: dat_nxt[2:0] = epen_r;
        IDX_IRQ_PENDING: dat_nxt[NUM_SRC-1:0] = pend_r;
        IDX_PROC_STATUS:
        begin
          dat_nxt[PSC_GIE_BIT] = gie_r;
          dat_nxt[PSC_PENDING_BIT] = |pend_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gen_r <= GLOBAL_EN_RESET;
      epen_r <= EP_EN_RESET;
      pin_en_r <= '0;
      pol_r <= '0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      gen_r <= gen_nxt;
      epen_r <= epen_nxt;
      pin_en_r <= pin_en_nxt;
      pol_r <= pol_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign wake_timer_run_o = gen_r[GE_WAKE];

  // bus reset / ps2 persistence timer
  always_comb
  begin
    bcnt_nxt = bcnt_r;
    bus_evt = 1'b0;
    if (!bus_cond_i)
      bcnt_nxt = 16'h0000;
    else if (bcnt_r < 16'(PERSIST_CYC))
    begin
      bcnt_nxt = bcnt_r + 16'h0001;
      bus_evt = (bcnt_nxt == 16'(PERSIST_CYC));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bcnt_r <= 16'h0000;
    else if (ce_i)
      bcnt_r <= bcnt_nxt;
  end

  // pending flops, enables and global enable
  always_comb
  begin
    set_vec = '0;
    set_vec[SRC_BUS] = bus_evt;
    set_vec[SRC_T128] = tmr128_evt_i;
    set_vec[SRC_T1024] = tmr1024_evt_i;
    set_vec[SRC_EP0] = ep0_evt_i;
    set_vec[SRC_EP1] = ep1_evt_i;
    set_vec[SRC_EP2] = ep2_evt_i;
    set_vec[SRC_SPI] = spi_byte_done_i;
    set_vec[SRC_CAPA] = capa_evt_i;
    set_vec[SRC_CAPB] = capb_evt_i;
    set_vec[SRC_GPIO] = gpio_fire;
    set_vec[SRC_WAKE] = wake_evt_i & gen_r[GE_WAKE];
    en_vec = '0;
    en_vec[SRC_BUS] = gen_r[GE_BUS];
    en_vec[SRC_T128] = gen_r[GE_T128];
    en_vec[SRC_T1024] = gen_r[GE_T1024];
    en_vec[SRC_EP0] = epen_r[0];
    en_vec[SRC_EP1] = epen_r[1];
    en_vec[SRC_EP2] = epen_r[2];
    en_vec[SRC_SPI] = gen_r[GE_SPI];
    en_vec[SRC_CAPA] = gen_r[GE_CAPA];
    en_vec[SRC_CAPB] = gen_r[GE_CAPB];
    en_vec[SRC_GPIO] = gen_r[GE_GPIO];
    en_vec[SRC_WAKE] = gen_r[GE_WAKE];
    req_vec = pend_r & en_vec;
    take = (st_r == SEQ_IDLE) & instr_done_i & gie_r & (|req_vec);
    pend_nxt = pend_r;
    gie_nxt = gie_r;
    if (irq_off_instruction_i)
      gie_nxt = 1'b0;
    if (irq_on_instruction_i || return_from_handler_instruction_i)
      gie_nxt = 1'b1;
    if (take)
    begin
      gie_nxt = 1'b0;
      pend_nxt[pick_first(req_vec)] = 1'b0;
    end
    pend_nxt = pend_nxt | set_vec;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_r <= '0;
      gie_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pend_r <= pend_nxt;
      gie_r <= gie_nxt;
    end
  end

  // acknowledge sequencer: call then vector jump
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    vidx_nxt = vidx_r;
    push_nxt = 1'b0;
    vval_nxt = 1'b0;
    rv_nxt = 1'b0;
    ppc_nxt = ppc_r;
    pc_nxt = pc_r;
    pz_nxt = pz_r;
    fetch_nxt = fetch_r;
    rpc_nxt = rpc_r;
    rc_nxt = rc_r;
    rz_nxt = rz_r;
    if (return_from_handler_instruction_i)
    begin
      rv_nxt = 1'b1;
      rpc_nxt = pop_pc_i;
      rc_nxt = pop_carry_flag_i;
      rz_nxt = pop_zero_flag_i;
    end
    unique case (st_r)
      SEQ_IDLE:
      begin
        if (take)
        begin
          st_nxt = SEQ_CALL;
          cnt_nxt = 4'h0;
          vidx_nxt = pick_first(req_vec);
          ppc_nxt = pc_i;
          pc_nxt = carry_flag_i;
          pz_nxt = zero_flag_i;
        end
      end
      SEQ_CALL:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'(CALL_CYCLES - 1))
        begin
          st_nxt = SEQ_JUMP;
          cnt_nxt = 4'h0;
          push_nxt = 1'b1;
          vval_nxt = 1'b1;
          fetch_nxt = vector_of(vidx_r);
        end
      end
      SEQ_JUMP:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'(JUMP_CYCLES - 1))
        begin
          st_nxt = SEQ_IDLE;
          cnt_nxt = 4'h0;
        end
      end
      default: st_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= SEQ_IDLE;
      cnt_r <= 4'h0;
      vidx_r <= 4'h0;
      push_r <= 1'b0;
      vval_r <= 1'b0;
      rv_r <= 1'b0;
      ppc_r <= 16'h0000;
      pc_r <= 1'b0;
      pz_r <= 1'b0;
      fetch_r <= RESET_VECTOR;
      rpc_r <= 16'h0000;
      rc_r <= 1'b0;
      rz_r <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      vidx_r <= vidx_nxt;
      push_r <= push_nxt;
      vval_r <= vval_nxt;
      rv_r <= rv_nxt;
      ppc_r <= ppc_nxt;
      pc_r <= pc_nxt;
      pz_r <= pz_nxt;
      fetch_r <= fetch_nxt;
      rpc_r <= rpc_nxt;
      rc_r <= rc_nxt;
      rz_r <= rz_nxt;
    end
  end

  assign cpu_hold_o = (st_r != SEQ_IDLE);
  assign stack_push_o = push_r;
  assign push_pc_o = ppc_r;
  assign push_carry_flag_o = pc_r;
  assign push_zero_flag_o = pz_r;
  assign vector_valid_o = vval_r;
  assign fetch_addr_o = fetch_r;
  assign restore_valid_o = rv_r;
  assign restore_pc_o = rpc_r;
  assign restore_carry_flag_o = rc_r;
  assign restore_zero_flag_o = rz_r;
endmodule : pic_ctrl

// [tb/pic_ctrl_assertions.sv]
`timescale 1ns/1ps
module pic_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic instr_done_i,
  input wire logic return_from_handler_instruction_i,
  input wire logic [15:0] pc_i,
  input wire logic carry_flag_i,
  input wire logic [15:0] pop_pc_i,
  input wire logic cpu_hold_o,
  input wire logic stack_push_o,
  input wire logic [15:0] push_pc_o,
  input wire logic push_carry_flag_o,
  input wire logic vector_valid_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic restore_valid_o,
  input wire logic [15:0] restore_pc_o,
  input wire logic wake_timer_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus access not answered in one cycle");
  AST_HOLD: assert property ($rose(cpu_hold_o) |->
    cpu_hold_o [*8] ##1 cpu_hold_o [*7] ##1 !cpu_hold_o)
    else $error("acknowledge hold not 15 cycles");
  AST_PUSH: assert property ($rose(cpu_hold_o) |->
    ##10 stack_push_o && vector_valid_o)
    else $error("call not made 10 cycles after take");
  AST_PCPUSH: assert property (stack_push_o |->
    push_pc_o == $past(pc_i, 11) && push_carry_flag_o == $past(carry_flag_i, 11))
    else $error("pushed state differs from state at take");
  AST_VEC: assert property (vector_valid_o |-> !fetch_addr_o[0] &&
    fetch_addr_o >= 16'h0002 && fetch_addr_o <= 16'h0016)
    else $error("vector address outside table");
  AST_TAKE: assert property ($rose(cpu_hold_o) |-> $past(instr_done_i))
    else $error("service began inside an instruction");
  AST_RET: assert property (return_from_handler_instruction_i |=>
    restore_valid_o && restore_pc_o == $past(pop_pc_i))
    else $error("return did not restore program counter");
  AST_VECHOLD: assert property (vector_valid_o |-> cpu_hold_o [*5] ##1 !cpu_hold_o)
    else $error("jump phase not 5 cycles");
  AST_RST: assert property (disable iff (1'b0) $fell(rst_i) |->
    !cpu_hold_o && !wake_timer_run_o && fetch_addr_o == 16'h0000)
    else $error("state not cleared by reset");
endmodule : pic_ctrl_assertions

bind pic_ctrl pic_ctrl_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .instr_done_i, .return_from_handler_instruction_i, .pc_i, .carry_flag_i, .pop_pc_i,
  .cpu_hold_o, .stack_push_o, .push_pc_o, .push_carry_flag_o, .vector_valid_o,
  .fetch_addr_o, .restore_valid_o, .restore_pc_o, .wake_timer_run_o);

// [tb/pic_cpu_model.sv]
`timescale 1ns/1ps
// cpu sequencer: 3-cycle instructions, stack of pushed pc values
module pic_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic push_i,
  input wire logic [15:0] push_pc_i,
  input wire logic [2:0] req_i,
  output logic done_o,
  output logic [2:0] op_o,
  output logic [15:0] pc_o,
  output logic [15:0] pop_pc_o
);
  logic [1:0] cnt_r;
  logic [15:0] stk[$];
  assign done_o = cnt_r == 2'h2 && !hold_i;
  assign op_o = done_o ? req_i : 3'h0;
  always @(posedge clk_i)
  begin
    cnt_r <= (rst_i || hold_i || done_o) ? 2'h0 : cnt_r + 2'h1;
    pc_o <= rst_i ? 16'h0100 : pc_o + {15'h0, done_o};
    if (push_i)
      stk.push_back(push_pc_i);
    if (op_o[2] && stk.size() > 0)
      void'(stk.pop_back());
    // empty stack shows a changing pattern
    pop_pc_o <= (stk.size() > 0) ? stk[$] : ~pop_pc_o;
  end
endmodule : pic_cpu_model

// [tb/test_pic_ctrl.sv]
`timescale 1ns/1ps
module test_pic_ctrl;
  import pic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [10:0] ev = 11'h000;
  logic [15:0] pins = 16'h0001;
  logic [2:0] req = 3'h0;
  logic [2:0] op;
  logic ack, done, hold, push, vv, rv, wake, pcf, pzf, rcf, rzf;
  logic [15:0] pc, ppc, pop, fa, rpc, q;
  int mismatches = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  pic_ctrl #(.PINS(16), .PERSIST_CYC(20)) dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .bus_cond_i(ev[0]), .tmr128_evt_i(ev[1]),
    .tmr1024_evt_i(ev[2]), .ep0_evt_i(ev[3]), .ep1_evt_i(ev[4]), .ep2_evt_i(ev[5]),
    .spi_byte_done_i(ev[6]), .capa_evt_i(ev[7]), .capb_evt_i(ev[8]), .wake_evt_i(ev[10]),
    .gpio_pins_i(pins), .instr_done_i(done), .irq_on_instruction_i(op[0]),
    .irq_off_instruction_i(op[1]), .return_from_handler_instruction_i(op[2]),
    .pc_i(pc), .carry_flag_i(pc[0]), .zero_flag_i(pc[1]), .pop_pc_i(pop),
    .pop_carry_flag_i(pop[0]), .pop_zero_flag_i(pop[1]), .cpu_hold_o(hold),
    .stack_push_o(push), .push_pc_o(ppc), .push_carry_flag_o(pcf), .push_zero_flag_o(pzf),
    .vector_valid_o(vv), .fetch_addr_o(fa), .restore_valid_o(rv), .restore_pc_o(rpc),
    .restore_carry_flag_o(rcf), .restore_zero_flag_o(rzf), .wake_timer_run_o(wake));
  pic_cpu_model cpu (.clk_i, .rst_i, .hold_i(hold), .push_i(push), .push_pc_i(ppc),
    .req_i(req), .done_o(done), .op_o(op), .pc_o(pc), .pop_pc_o(pop));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat[15:0];
    cyc <= 1'b0;
    chk(16'(n < 50), 16'h1);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  // k: 1 enable, 2 disable, 4 return
  task automatic ins(input logic [2:0] k);
    int n = 0;
    req <= k;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (op !== k && n < 50);
    req <= 3'h0;
    chk(16'(n < 50), 16'h1);
  endtask : ins
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic quiet(input int n);
    int c = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      c += (hold === 1'b1);
    end
    chk(16'(c), 16'h0);
  endtask : quiet
  task automatic serve(input logic [15:0] e, input logic on, input logic [15:0] p);
    int n = 0;
    logic [15:0] s;
    if (on)
      ins(3'h1);
    while (vv !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(16'(n < 100), 16'h1);
    chk(fa, e);
    // model pc moved on once at the take
    s = pc - 16'h0001;
    chk(ppc, s);
    chk({14'h0, pcf, pzf}, {14'h0, s[0], s[1]});
    rd(IDX_PROC_STATUS, (p != 0) ? 16'h0080 : 16'h0000);
    rd(IDX_IRQ_PENDING, p);
    ins(3'h4);
    @(posedge clk_i);
    chk(rpc, s);
    chk({13'h0, rv, rcf, rzf}, {13'h0, 1'b1, s[0], s[1]});
  endtask : serve
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(fa, RESET_VECTOR);
    rd(IDX_GLOBAL_IRQ_EN, 16'h0);
    rd(IDX_EP_IRQ_EN, 16'h0);
    rd(IDX_PROC_STATUS, 16'h0);
    rd(8'h30, 16'h0);
    wb(1'b1, IDX_IRQ_PENDING, 8'hFF);
    rd(IDX_IRQ_PENDING, 16'h0);
    $display("test 1 done");
    pulse(1);
    rd(IDX_IRQ_PENDING, 16'h0002);
    rd(IDX_PROC_STATUS, 16'h0080);
    ins(3'h1);
    quiet(20);
    rd(IDX_PROC_STATUS, 16'h0084);
    ins(3'h2);
    rd(IDX_PROC_STATUS, 16'h0080);
    wb(1'b1, IDX_GLOBAL_IRQ_EN, 8'h02);
    serve(16'h0004, 1'b1, 16'h0);
    rd(IDX_PROC_STATUS, 16'h0004);
    $display("test 2 done");
    wb(1'b1, IDX_GLOBAL_IRQ_EN, 8'hFF);
    wb(1'b1, IDX_EP_IRQ_EN, 8'h07);
    rd(IDX_GLOBAL_IRQ_EN, 16'h00FF);
    chk({15'h0, wake}, 16'h1);
    for (int i = 2; i <= 10; i++)
    begin
      if (i == 9)
        continue;
      pulse(i);
      serve(16'(2 + 2 * i), 1'b0, 16'h0);
    end
    ins(3'h2);
    pulse(3);
    pulse(2);
    serve(16'h0006, 1'b1, 16'h0008);
    serve(16'h0008, 1'b0, 16'h0);
    $display("test 3 done");
    wb(1'b1, IDX_PORT0_IRQ_POL, 8'h02);
    wb(1'b1, IDX_PORT0_IRQ_EN, 8'h03);
    pins <= 16'h0000;
    serve(16'h0014, 1'b0, 16'h0);
    pins <= 16'h0002;
    quiet(20);
    pins <= 16'h0003;
    quiet(10);
    pins <= 16'h0001;
    quiet(10);
    pins <= 16'h0003;
    serve(16'h0014, 1'b0, 16'h0);
    pins <= 16'h0001;
    wb(1'b1, IDX_PORT1_IRQ_POL, 8'h01);
    wb(1'b1, IDX_PORT1_IRQ_EN, 8'h01);
    pins <= 16'h0101;
    serve(16'h0014, 1'b0, 16'h0);
    wb(1'b1, IDX_GLOBAL_IRQ_EN, 8'h3F);
    pins <= 16'h0000;
    quiet(20);
    rd(IDX_IRQ_PENDING, 16'h0);
    chk({15'h0, wake}, 16'h0);
    pulse(10);
    quiet(10);
    rd(IDX_IRQ_PENDING, 16'h0);
    $display("test 4 done");
    ev[0] <= 1'b1;
    quiet(15);
    serve(16'h0002, 1'b0, 16'h0);
    ev[0] <= 1'b0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_GLOBAL_IRQ_EN, 16'h0);
    rd(IDX_PROC_STATUS, 16'h0);
    chk(fa, RESET_VECTOR);
    $display("test 5 done");
    finish_test();
  end
endmodule : test_pic_ctrl
